/* File: wdl_pkg.sv */
package wdl_pkg;
    // Clocking
    localparam int CLK_MHZ = 250;
    localparam int CK_HALF = 4;
    localparam int CK_DIV  = 2 * CK_HALF;
    localparam int CK_NS   = CK_DIV * 1000 / CLK_MHZ;

    // Command bus and mode register one layout
    localparam int ADDR_W      = 13;
    localparam int BA_W        = 3;
    localparam logic [2:0] MR1_BANK = 3'h1;
    localparam int LVL_EN_BIT  = 7;
    localparam int OUT_DIS_BIT = 12;
    localparam int RTT0_BIT    = 2;
    localparam int RTT1_BIT    = 6;
    localparam int RTT2_BIT    = 9;

    // Nominal termination codes; all but RTT_OFF usable with outputs on
    localparam logic [2:0] RTT_OFF  = 3'h0;
    localparam logic [2:0] RTT_RZQ4 = 3'h1;
    localparam logic [2:0] RTT_RZQ2 = 3'h2;
    localparam logic [2:0] RTT_RZQ6 = 3'h3;

    // Byte lanes
    localparam int LANES  = 2;
    localparam int LANE_W = 8;
    localparam int DQ_W   = LANES * LANE_W;

    // Times in link clock cycles
    localparam int MOD_NCK     = 12;
    localparam int MRD_NCK     = 4;
    localparam int DQSEN_NCK   = 25;
    localparam int WLMRD_NCK   = 40;
    localparam int ODT_OFF_NCK = 10;

    // Times in ns
    localparam int DQSL_NS = 12;
    localparam int WLO_NS  = 9;
    localparam int WLOE_NS = 2;
    localparam int IS_NS   = 1;

    // Least time to clock_i cycles, rounded up
    function automatic int ns_min(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    // Longest time to cycles of a period, rounded down
    function automatic int ns_max(input int ns, input int per);
        int c;
        c = ns / per;
        return (c < 1) ? 1 : c;
    endfunction

    // Derived counts, clock_i cycles unless noted
    localparam int MOD_CYC   = MOD_NCK * CK_DIV;
    localparam int MRD_CYC   = MRD_NCK * CK_DIV;
    localparam int DQSEN_CYC = DQSEN_NCK * CK_DIV;
    localparam int DQSL_CYC  = ns_min(DQSL_NS);
    localparam int WLMRD_CYC = WLMRD_NCK * CK_DIV;
    localparam int FIRST_CYC = (DQSL_CYC > WLMRD_CYC) ? DQSL_CYC : WLMRD_CYC;
    localparam int ODT_OFF_CYC = ODT_OFF_NCK * CK_DIV + ns_min(IS_NS);
    localparam int WLO_CK    = ns_max(WLO_NS, CK_NS);
    localparam int WLOE_CYC  = ns_min(WLOE_NS);
    localparam int PULSE_CYC = 2 * CK_DIV;
    localparam int FB_CYC    = (WLO_CK + 6) * CK_DIV + WLOE_CYC + 2;

    // Register map
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STAT = 12'h004;
    localparam logic [11:0] REG_RES  = 12'h008;
    localparam int CTRL_START    = 0;
    localparam int CTRL_RTT_LSB  = 1;
    localparam int CTRL_ODIS     = 4;
    localparam int STAT_BUSY     = 0;
    localparam int STAT_DONE     = 1;
    localparam int STAT_FAIL     = 2;
    localparam int STAT_LOCK_LSB = 3;
    localparam int RES_HI_LSB    = 8;
endpackage

/* File: wdl_if.sv */
`timescale 1ns/1ps
interface wdl_if;
    // Link clock and commands, made by the controller
    logic                     ck;
    logic                     cmd_mrs;
    logic [wdl_pkg::BA_W-1:0]   ba;
    logic [wdl_pkg::ADDR_W-1:0] addr;
    logic                     odt;
    // Strobe pairs, one per byte lane
    logic [wdl_pkg::LANES-1:0]  dqs;
    logic [wdl_pkg::LANES-1:0]  dqs_n;
    logic [wdl_pkg::LANES-1:0]  dqs_oe;
    // Data bits, driven by the memory while leveling
    logic [wdl_pkg::DQ_W-1:0]   dq;
    logic                     dq_oe;
    logic                     dq_valid;
    // Termination state seen at the memory
    logic [wdl_pkg::LANES-1:0]  dqs_term;
    logic                     dq_term;

    modport ctrl (
        output ck, cmd_mrs, ba, addr, odt, dqs, dqs_n, dqs_oe,
        input  dq, dq_oe, dq_valid, dqs_term, dq_term
    );
    modport mem (
        input  ck, cmd_mrs, ba, addr, odt, dqs, dqs_n, dqs_oe,
        output dq, dq_oe, dq_valid, dqs_term, dq_term
    );
endinterface

/* File: wdl_mem.sv */
`timescale 1ns/1ps
module wdl_mem (
    // Reset
    input  wire logic reset_i,
    // Link
    wdl_if.mem        lnk,
    // Mode state
    output logic      lvl_mode_o,
    output logic      out_dis_o
);
    localparam int L = wdl_pkg::LANES;

    logic         lvl_q;
    logic         odis_q;
    logic [2:0]   rtt_q;
    logic [7:0]   mod_cnt_q;
    logic         odt_s1_q, odt_s2_q;
    logic [L-1:0] dqs_s1_q, dqs_s2_q, dqs_s3_q;
    logic         phase_q;
    logic [L-1:0] samp_q, fb_q, fb_seen_q;
    logic [3:0]   wlo_cnt_q [L];
    logic [L-1:0] dqs_term_q;
    logic         dq_term_q;
    logic [wdl_pkg::DQ_W-1:0] dq_q;
    logic         dq_oe_q, dq_valid_q;

    // Command decode and strobe edge detect
    wire          mr1_wr   = lnk.cmd_mrs && (lnk.ba == wdl_pkg::MR1_BANK);
    wire          settled  = (mod_cnt_q == 8'h00);
    wire [L-1:0]  dqs_rise = dqs_s2_q & ~dqs_s3_q;

    always_ff @(posedge lnk.ck or posedge reset_i)
    begin
        if (reset_i)
        begin
            lvl_q     <= 1'b0;
            odis_q    <= 1'b0;
            rtt_q     <= 3'h0;
            mod_cnt_q <= 8'h00;
        end
        else if (mr1_wr)
        begin
            lvl_q     <= lnk.addr[wdl_pkg::LVL_EN_BIT];
            odis_q    <= lnk.addr[wdl_pkg::OUT_DIS_BIT];
            rtt_q     <= {lnk.addr[wdl_pkg::RTT2_BIT],
                          lnk.addr[wdl_pkg::RTT1_BIT],
                          lnk.addr[wdl_pkg::RTT0_BIT]};
            mod_cnt_q <= 8'(wdl_pkg::MOD_NCK);
        end
        else if (!settled)
            mod_cnt_q <= mod_cnt_q - 8'h01;
    end

    // Pin synchronisers and reference phase
    always_ff @(posedge lnk.ck or posedge reset_i)
    begin
        if (reset_i)
        begin
            odt_s1_q <= 1'b0;
            odt_s2_q <= 1'b0;
            dqs_s1_q <= '0;
            dqs_s2_q <= '0;
            dqs_s3_q <= '0;
            phase_q  <= 1'b0;
        end
        else
        begin
            odt_s1_q <= lnk.odt;
            odt_s2_q <= odt_s1_q;
            dqs_s1_q <= lnk.dqs & lnk.dqs_oe;
            dqs_s2_q <= dqs_s1_q;
            dqs_s3_q <= dqs_s2_q;
            phase_q  <= ~phase_q;
        end
    end

    // Per lane sample and feedback delay, one process for all lanes
    // sample on strobe rise
    always_ff @(posedge lnk.ck or posedge reset_i)
    begin
        if (reset_i)
        begin
            samp_q    <= '0;
            fb_q      <= '0;
            fb_seen_q <= '0;
            for (int i = 0; i < L; i++)
                wlo_cnt_q[i] <= 4'h0;
        end
        else
        begin
            for (int i = 0; i < L; i++)
            if (!lvl_q)
            begin
                fb_seen_q[i] <= 1'b0;
                wlo_cnt_q[i] <= 4'h0;
            end
            else if (dqs_rise[i] && settled)
            begin
                samp_q[i]    <= phase_q;
                wlo_cnt_q[i] <= 4'(wdl_pkg::WLO_CK);
            end
            else if (wlo_cnt_q[i] == 4'h1)
            begin
                fb_q[i]      <= samp_q[i];
                fb_seen_q[i] <= 1'b1;
                wlo_cnt_q[i] <= 4'h0;
            end
            else if (wlo_cnt_q[i] != 4'h0)
                wlo_cnt_q[i] <= wlo_cnt_q[i] - 4'h1;
        end
    end

    // Termination and data drive
    always_ff @(posedge lnk.ck or posedge reset_i)
    begin
        if (reset_i)
        begin
            dqs_term_q <= '0;
            dq_term_q  <= 1'b0;
            dq_q       <= '0;
            dq_oe_q    <= 1'b0;
            dq_valid_q <= 1'b0;
            lvl_mode_o <= 1'b0;
            out_dis_o  <= 1'b0;
        end
        else
        begin
            dqs_term_q <= {L{odt_s2_q && (lvl_q || rtt_q != 3'h0)}};
            dq_term_q  <= odt_s2_q && !lvl_q && (rtt_q != 3'h0);
            // level copied on every lane bit
            // all bits of a lane launched together
            dq_q       <= {{wdl_pkg::LANE_W{fb_q[1]}},
                           {wdl_pkg::LANE_W{fb_q[0]}}};
            dq_oe_q    <= (lvl_q || !settled) && !odis_q;
            dq_valid_q <= lvl_q && settled && !odis_q && (&fb_seen_q);
            lvl_mode_o <= lvl_q;
            out_dis_o  <= odis_q;
        end
    end

    // Pin drive
    assign lnk.dqs_term = dqs_term_q;
    assign lnk.dq_term  = dq_term_q;
    assign lnk.dq       = dq_q;
    assign lnk.dq_oe    = dq_oe_q;
    assign lnk.dq_valid = dq_valid_q;
endmodule

/* File: wdl_ctl.sv */
`timescale 1ns/1ps
// Function
// - Leveling bit set enters, cleared leaves
// - In leveling odt switches strobe termination only
// - Outputs on: only RZQ/2, /4, /6
// - Only nop or leveling exit command
// - Data bits undefined after entry
// - Level one rank, others outputs disabled
// - Odt only after mode update delay
// - Strobe low after strobe enable delay
// - Single strobe rise after low and first delays
// - Memory returns sampled clock on data bits
// - Tolerate skew between feedback bits
// - Step delay, lock on 0 to 1
// - Two byte lanes leveled independently
// - Stop strobes after last rising edge
// - Odt low with setup, kept low
// - Leveling off command after termination off
// - Wait mode delays before next commands
module wdl_ctl #(
    parameter int DLY_W = 6
) (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Link
    wdl_if.ctrl              lnk
);
    localparam int L = wdl_pkg::LANES;
    localparam logic [DLY_W:0] PEND = (DLY_W + 1)'((1 << DLY_W) - 1
                                       + wdl_pkg::PULSE_CYC);

    // Refuse delay widths the pulse counter cannot serve
    if (DLY_W < 5 || DLY_W > 8 || wdl_pkg::PULSE_CYC > (1 << DLY_W))
    begin : g_dly_chk
        $error("wdl_ctl: DLY_W out of range");
    end

    typedef enum logic [3:0] {
        WDL_IDLE, WDL_MRS_ON, WDL_MOD, WDL_DQSEN, WDL_ARM, WDL_PULSE,
        WDL_FB, WDL_EVAL, WDL_ODT_OFF, WDL_MRS_OFF, WDL_EXIT
    } wdl_state_e;

    wdl_state_e        st_q;
    logic [15:0]       tmr_q;
    logic [DLY_W:0]    pcnt_q;
    logic [DLY_W-1:0]  dly_q [L];
    logic [L-1:0]      lock_q, seen0_q;
    logic              done_q, fail_q;
    logic [2:0]        rtt_q;
    logic              odis_q;
    logic [2:0]        div_q;
    logic              ck_q, cmd_q, mrs_req_q, lvl_bit_q, odt_q;
    logic [L-1:0]      dqs_q, dqs_oe_q;
    logic [wdl_pkg::DQ_W-1:0] dq_s1_q, dq_s2_q;
    logic              val_s1_q, val_s2_q;

    // APB decode
    wire acc    = psel_i && penable_i && pready_o;
    wire wr     = acc && pwrite_i;
    wire a_ctrl = (paddr_i == wdl_pkg::REG_CTRL);
    wire a_stat = (paddr_i == wdl_pkg::REG_STAT);
    wire a_res  = (paddr_i == wdl_pkg::REG_RES);
    wire a_ok   = a_ctrl || a_stat || a_res;
    wire start  = wr && a_ctrl && pwdata_i[wdl_pkg::CTRL_START];
    wire busy   = (st_q != WDL_IDLE);
    wire tmr_z  = (tmr_q == 16'h0000);

    // termination legal for outputs on, judged on the word written
    wire [2:0] new_rtt  = pwdata_i[wdl_pkg::CTRL_RTT_LSB +: 3];
    wire       new_odis = pwdata_i[wdl_pkg::CTRL_ODIS];
    wire rtt_ok = new_odis
                  || new_rtt == wdl_pkg::RTT_RZQ2
                  || new_rtt == wdl_pkg::RTT_RZQ4
                  || new_rtt == wdl_pkg::RTT_RZQ6;

    // Read mux
    wire [31:0] stat_w = 32'({lock_q, fail_q, done_q, busy});
    wire [31:0] res_w  = (32'(dly_q[1]) << wdl_pkg::RES_HI_LSB)
                       | 32'(dly_q[0]);
    wire [31:0] ctrl_w = 32'({odis_q, rtt_q, 1'b0});
    wire [31:0] rd_w   = a_ctrl ? ctrl_w : a_stat ? stat_w
                       : a_res ? {16'h0000, res_w[15:0]} : 32'h0000_0000;

    // Link clock edge and command requests
    wire ck_fall = (div_q == 3'(wdl_pkg::CK_HALF - 1)) && ck_q;
    wire mrs_go  = (st_q == WDL_IDLE && start && rtt_ok)
                   || (st_q == WDL_ODT_OFF && tmr_z);

    // Lane feedback: all bits of the lane must read high
    function automatic logic lane_fb(input logic [wdl_pkg::DQ_W-1:0] d,
                                     input int i);
        return &d[i*wdl_pkg::LANE_W +: wdl_pkg::LANE_W];
    endfunction

    // APB slave handshake
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            rtt_q     <= wdl_pkg::RTT_RZQ2;
            odis_q    <= 1'b0;
        end
        else
        begin
            pready_o  <= psel_i && penable_i && !pready_o;
            pslverr_o <= psel_i && penable_i && !pready_o && !a_ok;
            prdata_o  <= rd_w;
            if (wr && a_ctrl && !busy)
            begin
                rtt_q  <= pwdata_i[wdl_pkg::CTRL_RTT_LSB +: 3];
                odis_q <= pwdata_i[wdl_pkg::CTRL_ODIS];
            end
        end
    end

    // Link clock divider and command slot
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            div_q     <= 3'h0;
            ck_q      <= 1'b0;
            cmd_q     <= 1'b0;
            mrs_req_q <= 1'b0;
        end
        else
        begin
            div_q <= ck_fall || div_q == 3'(wdl_pkg::CK_HALF - 1)
                     ? 3'h0 : div_q + 3'h1;
            if (div_q == 3'(wdl_pkg::CK_HALF - 1))
                ck_q <= ~ck_q;
            // only nop or mode register set
            if (ck_fall)
                cmd_q <= mrs_req_q;
            if (mrs_go)
                mrs_req_q <= 1'b1;
            else if (ck_fall)
                mrs_req_q <= 1'b0;
        end
    end

    // Feedback synchroniser
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            dq_s1_q  <= '0;
            dq_s2_q  <= '0;
            val_s1_q <= 1'b0;
            val_s2_q <= 1'b0;
        end
        else
        begin
            dq_s1_q  <= lnk.dq;
            dq_s2_q  <= dq_s1_q;
            val_s1_q <= lnk.dq_valid && lnk.dq_oe;
            val_s2_q <= val_s1_q;
        end
    end

    // Sequencer
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_q      <= WDL_IDLE;
            tmr_q     <= 16'h0000;
            pcnt_q    <= '0;
            lvl_bit_q <= 1'b0;
            odt_q     <= 1'b0;
            dqs_oe_q  <= '0;
            dqs_q     <= '0;
            lock_q    <= '0;
            seen0_q   <= '0;
            done_q    <= 1'b0;
            fail_q    <= 1'b0;
            for (int i = 0; i < L; i++)
                dly_q[i] <= '0;
        end
        else
        begin
            if (!tmr_z)
                tmr_q <= tmr_q - 16'h0001;
            case (st_q)
                WDL_IDLE:
                    if (start)
                    begin
                        done_q  <= 1'b0;
                        fail_q  <= !rtt_ok;
                        lock_q  <= '0;
                        seen0_q <= '0;
                        for (int i = 0; i < L; i++)
                            dly_q[i] <= '0;
                        if (rtt_ok)
                        begin
                            lvl_bit_q <= 1'b1;
                            st_q      <= WDL_MRS_ON;
                        end
                    end
                WDL_MRS_ON:
                    if (!mrs_req_q)
                    begin
                        tmr_q <= 16'(wdl_pkg::MOD_CYC);
                        st_q  <= WDL_MOD;
                    end
                WDL_MOD:
                    if (tmr_z)
                    begin
                        odt_q <= 1'b1;
                        tmr_q <= 16'(wdl_pkg::DQSEN_CYC);
                        st_q  <= WDL_DQSEN;
                    end
                WDL_DQSEN:
                    if (tmr_z)
                    begin
                        dqs_oe_q <= {L{1'b1}};
                        tmr_q    <= 16'(wdl_pkg::FIRST_CYC);
                        st_q     <= WDL_ARM;
                    end
                WDL_ARM:
                    if (tmr_z)
                    begin
                        pcnt_q <= '0;
                        st_q   <= WDL_PULSE;
                    end
                WDL_PULSE:
                begin
                    // each lane at its own delay
                    for (int i = 0; i < L; i++)
                        dqs_q[i] <= pcnt_q >= {1'b0, dly_q[i]}
                            && pcnt_q < {1'b0, dly_q[i]}
                               + (DLY_W + 1)'(wdl_pkg::PULSE_CYC);
                    pcnt_q <= pcnt_q + 1'b1;
                    if (pcnt_q == PEND)
                    begin
                        tmr_q <= 16'(wdl_pkg::FB_CYC);
                        st_q  <= WDL_FB;
                    end
                end
                WDL_FB:
                    if (tmr_z)
                        st_q <= WDL_EVAL;
                WDL_EVAL:
                begin
                    // step delay, lock on 0 to 1
                    for (int i = 0; i < L; i++)
                        if (!lock_q[i])
                        begin
                            if (val_s2_q && lane_fb(dq_s2_q, i) && seen0_q[i])
                                lock_q[i] <= 1'b1;
                            else if (&dly_q[i])
                                fail_q <= 1'b1;
                            else
                                dly_q[i] <= dly_q[i] + 1'b1;
                            if (!(val_s2_q && lane_fb(dq_s2_q, i)))
                                seen0_q[i] <= 1'b1;
                        end
                    tmr_q <= 16'(wdl_pkg::DQSL_CYC);
                    st_q  <= WDL_ARM;
                    if ((&lock_q) || fail_q)
                    begin
                        dqs_oe_q <= '0;
                        odt_q    <= 1'b0;
                        tmr_q    <= 16'(wdl_pkg::ODT_OFF_CYC);
                        st_q     <= WDL_ODT_OFF;
                    end
                end
                WDL_ODT_OFF:
                    if (tmr_z)
                    begin
                        lvl_bit_q <= 1'b0;
                        st_q      <= WDL_MRS_OFF;
                    end
                WDL_MRS_OFF:
                    if (!mrs_req_q)
                    begin
                        tmr_q <= 16'(wdl_pkg::MOD_CYC);
                        st_q  <= WDL_EXIT;
                    end
                WDL_EXIT:
                    // mode update delay covers command gap
                    if (tmr_z)
                    begin
                        done_q <= 1'b1;
                        st_q   <= WDL_IDLE;
                    end
                default:
                    st_q <= WDL_IDLE;
            endcase
        end
    end

    // Link drive; output disable bit carried in mode word
    assign lnk.ck      = ck_q;
    assign lnk.cmd_mrs = cmd_q;
    assign lnk.ba      = wdl_pkg::MR1_BANK;
    assign lnk.addr    = (13'(lvl_bit_q) << wdl_pkg::LVL_EN_BIT)
                       | (13'(odis_q) << wdl_pkg::OUT_DIS_BIT)
                       | (13'(rtt_q[0]) << wdl_pkg::RTT0_BIT)
                       | (13'(rtt_q[1]) << wdl_pkg::RTT1_BIT)
                       | (13'(rtt_q[2]) << wdl_pkg::RTT2_BIT);
    assign lnk.odt     = odt_q;
    assign lnk.dqs     = dqs_q;
    assign lnk.dqs_n   = ~dqs_q;
    assign lnk.dqs_oe  = dqs_oe_q;
endmodule

/* File: wdl_properties.sv */
`timescale 1ns/1ps
module wdl_properties (
    // Link signals
    input wire logic        reset_i,
    input wire logic        ck,
    input wire logic        cmd_mrs,
    input wire logic [2:0]  ba,
    input wire logic [12:0] addr,
    input wire logic        odt,
    input wire logic [1:0]  dqs,
    input wire logic [1:0]  dqs_n,
    input wire logic [1:0]  dqs_oe,
    input wire logic        dq_valid,
    input wire logic        dq_term
);
    logic       lvl_q;
    logic [7:0] gap_q;
    wire        en_w = cmd_mrs & addr[7];

    // Leveling state as set by mode commands
    always_ff @(posedge ck or posedge reset_i)
        if (reset_i)
            lvl_q <= 1'b0;
        else if (cmd_mrs)
            lvl_q <= addr[7];

    // Link cycles since the last mode command
    always_ff @(posedge ck or posedge reset_i)
        if (reset_i)
            gap_q <= 8'hFF;
        else
            gap_q <= cmd_mrs ? 8'h00 : gap_q + {7'h0, gap_q != 8'hFF};

    default clocking @(posedge ck); endclocking
    default disable iff (reset_i);

    a_mrs_bank: assert property (cmd_mrs |-> ba == wdl_pkg::MR1_BANK)
        else $error("mode command to wrong register");
    a_lvl_exit_only: assert property (cmd_mrs && lvl_q |-> !addr[7])
        else $error("command other than exit in leveling");
    a_mrs_gap: assert property (cmd_mrs |-> gap_q >= 8'd11)
        else $error("mode commands too close");
    a_odt_wait: assert property ($rose(odt) |-> lvl_q && gap_q >= 8'd11)
        else $error("odt before mode update delay");
    a_strobe_wait: assert property ($rose(dqs_oe[0]) |-> odt && gap_q >= 8'd25)
        else $error("strobes driven too early");
    a_strobe_pair: assert property (dqs_n == ~dqs)
        else $error("strobe pair not complementary");
    a_strobe_in_lvl: assert property (|dqs_oe |-> lvl_q)
        else $error("strobes driven outside leveling");
    a_exit_order: assert property (cmd_mrs && lvl_q |-> !odt && dqs_oe == 2'h0)
        else $error("exit command with odt or strobes on");
    a_odt_kept_low: assert property ($fell(odt) |-> !odt [*8])
        else $error("odt raised during exit");
    a_dq_term_off: assert property (|dqs_oe |-> !dq_term)
        else $error("data termination on in leveling");
    a_dq_undef: assert property (en_w |=> !dq_valid)
        else $error("feedback valid right after entry");

    // Main scenarios
    c_entry: cover property (en_w);
    c_upper: cover property ($rose(dqs[1]));
    c_exit: cover property ($fell(odt));
endmodule

/* File: tb_dram_write_leveling.sv */
`timescale 1ns/1ps
module tb_dram_write_leveling;
    logic        clock_i, reset_i, psel_i, penable_i, pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic        pready_o, pslverr_o, lvl_mode_o, out_dis_o;
    logic        sl_q;
    logic        bad_q = 1'b0;
    logic [12:0] mrs_a = '0;
    logic [2:0]  codes [3];
    int          err_total, n_tests, k;
    int          n_lvl = 0;

    wdl_if lnk ();
    wdl_ctl i_wdl_ctl (.clock_i(clock_i), .reset_i(reset_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .lnk(lnk.ctrl));
    wdl_mem i_wdl_mem (.reset_i(reset_i), .lnk(lnk.mem),
        .lvl_mode_o(lvl_mode_o), .out_dis_o(out_dis_o));
    wdl_properties i_wdl_properties (.reset_i(reset_i), .ck(lnk.ck),
        .cmd_mrs(lnk.cmd_mrs), .ba(lnk.ba), .addr(lnk.addr), .odt(lnk.odt),
        .dqs(lnk.dqs), .dqs_n(lnk.dqs_n), .dqs_oe(lnk.dqs_oe),
        .dq_valid(lnk.dq_valid), .dq_term(lnk.dq_term));

    // Clock
    initial
    begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    // Watch the link for entry and exit commands and stray data drive
    always @(posedge lnk.ck)
    begin
        if (lnk.cmd_mrs && lnk.addr[7])
            mrs_a <= lnk.addr;
        if (lnk.cmd_mrs && !lnk.addr[7] && lvl_mode_o)
            n_lvl <= n_lvl + 1;
        if (out_dis_o && lnk.dq_oe)
            bad_q <= 1'b1;
    end

    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask

    // One APB transfer, read data and error taken with pready
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_i);
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do
            @(posedge clock_i);
        while (pready_o !== 1'b1 && ++n < 50);
        if (n >= 50)
        begin
            err_total++;
            report_and_stop();
        end
        rd = prdata_o;
        sl_q = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // Poll status until not busy
    task automatic poll();
        for (int p = 0; p < 4000; p++)
        begin
            apb(1'b0, wdl_pkg::REG_STAT, 32'h0);
            if (rd[0] === 1'b0)
                break;
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog, about three times the longest expected run
    initial
    begin
        #200000;
        err_total++;
        report_and_stop();
    end

    initial
    begin
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        {err_total, n_tests} = '0;
        codes = '{wdl_pkg::RTT_RZQ4, wdl_pkg::RTT_RZQ2, wdl_pkg::RTT_RZQ6};
        reset_i = 1'b1;
        repeat (16) @(posedge clock_i);
        reset_i <= 1'b0;
        apb(1'b0, wdl_pkg::REG_CTRL, 32'h0);
        chk("ctrl_reset", rd, 32'h4);
        apb(1'b0, wdl_pkg::REG_STAT, 32'h0);
        chk("stat_reset", rd, 32'h0);
        apb(1'b1, 12'h00C, 32'hF);
        chk("slverr", {31'h0, sl_q}, 32'h1);
        apb(1'b0, 12'h00C, 32'h0);
        chk("unmapped", rd, 32'h0);
        // Illegal termination with outputs on is refused
        apb(1'b1, wdl_pkg::REG_CTRL, 32'hB);
        poll();
        chk("refused", rd & 32'h5, 32'h4);
        chk("no_entry", {19'h0, mrs_a}, 32'h0);
        // Each allowed termination, a write while busy ignored
        for (k = 0; k < 3; k++)
        begin
            apb(1'b1, wdl_pkg::REG_CTRL, {27'h0, 1'b0, codes[k], 1'b1});
            apb(1'b1, wdl_pkg::REG_CTRL, 32'h10);
            poll();
            chk("stat_done", rd, 32'h1A);
            chk("entry_addr", {19'h0, mrs_a}, {19'h0, 3'h0, codes[k][2],
                1'b0, 1'b1, codes[k][1], 3'h0, codes[k][0], 2'h0});
            chk("lvl_exits", n_lvl, k + 1);
            chk("lvl_left", {31'h0, lvl_mode_o}, 32'h0);
            apb(1'b0, wdl_pkg::REG_CTRL, 32'h0);
            chk("ctrl_kept", rd, {28'h0, codes[k], 1'b0});
            apb(1'b0, wdl_pkg::REG_RES, 32'h0);
            chk("lanes_ok", {31'h0, rd[5:0] != 6'h3F && rd[13:8] != 6'h3F},
                32'h1);
        end
        // Outputs disabled: any termination, no data drive
        apb(1'b1, wdl_pkg::REG_CTRL, 32'h1B);
        poll();
        chk("odis_stat", rd, 32'h6);
        chk("odis_kept", {31'h0, out_dis_o}, 32'h1);
        chk("odis_addr", {31'h0, mrs_a[12]}, 32'h1);
        chk("odis_quiet", {31'h0, bad_q}, 32'h0);
        report_and_stop();
    end
endmodule
